// [hw/ecdr_consts.vh]
// Constants of the engine IC configuration and diagnosis register bank.
// Assumes inclusion by bare name from the register bank source only.
`ifndef ECDR_CONSTS_VH
`define ECDR_CONSTS_VH

// ----------------------------------------
// Register offsets (4-bit address field)
// ----------------------------------------
`define ECDR_OFS_SENSOR_CFG 4'h0
`define ECDR_OFS_DIAG_ONE 4'h1
`define ECDR_OFS_DIAG_FIVE 4'h2
`define ECDR_OFS_POWER_CFG 4'h4
`define ECDR_OFS_DIAG_TWO 4'h5
`define ECDR_OFS_BRIDGE_ONE 4'h6
`define ECDR_OFS_DRIVER_CFG 4'h8
`define ECDR_OFS_DIAG_THREE 4'h9
`define ECDR_OFS_BRIDGE_TWO 4'ha
`define ECDR_OFS_DIAG_FOUR 4'hd

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ECDR_RST_SENSOR_CFG 8'hd8
`define ECDR_RST_POWER_CFG 8'h22
`define ECDR_RST_DRIVER_CFG 8'h50
`define ECDR_RST_STAGE_CFG 8'h01
`define ECDR_RST_DIAG 8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ECDR_SNS_ACT_MON 6
`define ECDR_SNS_DIAG_MINH 5
`define ECDR_SNS_MODE_FILT 4
`define ECDR_SNS_MODE_HYST 3
`define ECDR_PWR_XCVR_ERR 7
`define ECDR_PWR_KEY_RST 6
`define ECDR_PWR_LATCH_N 5
`define ECDR_PWR_KEEP_ON 4
`define ECDR_PWR_UV_MASK 3
`define ECDR_PWR_UV_SDO 2
`define ECDR_PWR_WD_BASE 1
`define ECDR_PWR_PRIO 0
`define ECDR_DRV_BAT_LATCH 7
`define ECDR_DRV_GND_SEL 6
`define ECDR_DRV_MASK_X2 5
`define ECDR_DRV_LB25 3
`define ECDR_DRV_LB21 2
`define ECDR_DRV_LB14 1
`define ECDR_DRV_LB13 0
`define ECDR_STG_BRIDGE 0

// ----------------------------------------
// Codes
// ----------------------------------------
`define ECDR_MODE_FULL 2'b11
`define ECDR_FIELD_OK 2'b11
`define ECDR_HYST_MIN 3'b001
`define ECDR_BR_SCG 8'h01
`define ECDR_BR_SCB 8'h05
`define ECDR_BR_OL_OFF 8'h04
`define ECDR_BR_OL_ON 8'h02
`define ECDR_BR_OVC 8'h03
`define ECDR_BR_RUN 8'h07
`define ECDR_BR_OK 8'hff
`define ECDR_DIAG5_TOP 4'hf

`endif

// [hw/ecdr_regs.v]
// Configuration and diagnosis register bank of the engine management IC.
// Assumes a serial channel front end that decodes write and read commands
// into one-cycle strobes with a 4-bit address, all on clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "ecdr_consts.vh"

module ecdr_regs (
	input wire clk_in,
	input wire resetn_in,
	input wire wr_en_in,
	input wire stage_cfg_wr_in,
	input wire rd_en_in,
	input wire [3:0] addr_in,
	input wire [7:0] wdata_in,
	output reg [7:0] rdata_out,
	output reg rvalid_out,
	input wire [7:0] stage1_4_status_in,
	input wire [7:0] stage5_8_status_in,
	input wire [1:0] stage9_status_in,
	input wire [3:0] stage13_14_status_in,
	input wire [7:0] stage15_18_status_in,
	input wire [3:0] stage19_20_status_in,
	input wire [7:0] stage21_24_status_in,
	input wire [7:0] stage25_28_status_in,
	input wire [7:0] bridge1_code_in,
	input wire [7:0] bridge2_code_in,
	input wire watchdog_pin_state_in,
	input wire key_on_in,
	input wire supply_uv_in,
	input wire sdo_data_in,
	input wire sdo_enable_in,
	output reg serial_data_out,
	output wire link_activity_monitor_enable_out,
	output wire sensor_diag_enable_out,
	output wire sensor_adapt_filter_out,
	output wire sensor_adapt_hyst_out,
	output wire [5:0] sensor_hyst_current_ua_out,
	output wire transceiver_error_enable_out,
	output wire key_on_reset_enable_out,
	output wire latch_secure_off_enabled_out,
	output wire supplies_off_out,
	output wire main_relay_driver_off_out,
	output wire uv_outputs_off_out,
	output wire watchdog_response_time_out,
	output wire secure_off_priority_out,
	output wire off_at_key_out,
	output wire off_on_watchdog_out,
	output wire off_at_timer_out,
	output wire secure_off_enable_out,
	output wire ignition_battery_diag_latch_out,
	output wire ignition_ground_diag_select_out,
	output wire diag_mask_double_out,
	output wire [3:0] low_battery_enable_out,
	output wire bridge_mode_out,
	output wire stages_independent_out
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Fault fields stick until read; a no-fault field takes the live code
	function [7:0] merge8;
		input [7:0] held;
		input [7:0] live;
		integer i;
		begin
			merge8 = held;
			for (i = 0; i < 4; i = i + 1) begin
				if (held[2*i +: 2] == `ECDR_FIELD_OK) begin
					merge8[2*i +: 2] = live[2*i +: 2];
				end
			end
		end
	endfunction

	function legal_bridge;
		input [7:0] code;
		begin
			case (code)
				`ECDR_BR_SCG, `ECDR_BR_SCB, `ECDR_BR_OL_OFF, `ECDR_BR_OL_ON,
				`ECDR_BR_OVC, `ECDR_BR_RUN, `ECDR_BR_OK: legal_bridge = 1'b1;
				default: legal_bridge = 1'b0;
			endcase
		end
	endfunction

	// Illegal live codes are read as no fault so they never escape
	function [7:0] bridge_next;
		input [7:0] held;
		input [7:0] live;
		input clr;
		reg [7:0] cand;
		begin
			cand = legal_bridge(live) ? live : `ECDR_BR_OK;
			// A held pattern that is no bridge code resyncs at once
			bridge_next = (clr || held == `ECDR_BR_OK || !legal_bridge(held)) ?
				cand : held;
		end
	endfunction

	function [5:0] hyst_ua;
		input [2:0] sel;
		begin
			case (sel)
				3'h1: hyst_ua = 6'h05;
				3'h2: hyst_ua = 6'h0a;
				3'h4: hyst_ua = 6'h20;
				3'h5: hyst_ua = 6'h33;
				3'h7: hyst_ua = 6'h00;
				default: hyst_ua = 6'h11;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [7:0] sensor_cfg_q;
	reg [7:0] power_cfg_q;
	reg [7:0] driver_cfg_q;
	reg [7:0] stage_cfg_q;
	reg [7:0] diag_one_q;
	reg [7:0] diag_two_q;
	reg [7:0] diag_three_q;
	reg [7:0] diag_four_q;
	reg [7:0] diag_five_q;
	reg [7:0] bridge_one_q;
	reg [7:0] bridge_two_q;
	reg [7:0] rdata_d;
	wire [7:0] diag_three_m;
	wire [7:0] diag_five_m;
	wire [7:0] bridge_one_d;
	wire [7:0] bridge_two_d;
	wire [7:0] bridge_one_rd;
	wire [7:0] bridge_two_rd;
	wire rd_one;
	wire rd_two;
	wire rd_three;
	wire rd_four;
	wire rd_five;
	wire rd_br_one;
	wire rd_br_two;
	wire full_adapt;
	wire uv_force_low;

	// ----------------------------------------
	// Read strobes
	// ----------------------------------------
	assign rd_one = rd_en_in && addr_in == `ECDR_OFS_DIAG_ONE;
	assign rd_two = rd_en_in && addr_in == `ECDR_OFS_DIAG_TWO;
	assign rd_three = rd_en_in && addr_in == `ECDR_OFS_DIAG_THREE;
	assign rd_four = rd_en_in && addr_in == `ECDR_OFS_DIAG_FOUR;
	assign rd_five = rd_en_in && addr_in == `ECDR_OFS_DIAG_FIVE;
	assign rd_br_one = rd_en_in && addr_in == `ECDR_OFS_BRIDGE_ONE;
	assign rd_br_two = rd_en_in && addr_in == `ECDR_OFS_BRIDGE_TWO;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Diagnosis offsets and unmapped offsets ignore writes
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sensor_cfg_q <= `ECDR_RST_SENSOR_CFG;
			power_cfg_q <= `ECDR_RST_POWER_CFG;
			driver_cfg_q <= `ECDR_RST_DRIVER_CFG;
			stage_cfg_q <= `ECDR_RST_STAGE_CFG;
		end else begin
			if (wr_en_in && addr_in == `ECDR_OFS_SENSOR_CFG) begin
				sensor_cfg_q <= wdata_in;
			end
			if (wr_en_in && addr_in == `ECDR_OFS_POWER_CFG) begin
				power_cfg_q <= wdata_in;
			end
			if (wr_en_in && addr_in == `ECDR_OFS_DRIVER_CFG) begin
				driver_cfg_q <= wdata_in;
			end
			if (stage_cfg_wr_in) begin
				stage_cfg_q <= wdata_in;
			end
		end
	end

	// ----------------------------------------
	// Diagnosis registers
	// ----------------------------------------
	// On a read the live code replaces the held one in the same edge, so
	// a fault arriving with the read is kept for the next read
	assign diag_three_m = merge8(diag_three_q,
		{stage13_14_status_in, `ECDR_FIELD_OK, stage9_status_in});
	assign diag_five_m = merge8(diag_five_q,
		{`ECDR_DIAG5_TOP, stage19_20_status_in});
	assign bridge_one_d = bridge_mode_out ?
		bridge_next(bridge_one_q, bridge1_code_in, rd_br_one) :
		(rd_br_one ? stage21_24_status_in : merge8(bridge_one_q, stage21_24_status_in));
	assign bridge_two_d = bridge_mode_out ?
		bridge_next(bridge_two_q, bridge2_code_in, rd_br_two) :
		(rd_br_two ? stage25_28_status_in : merge8(bridge_two_q, stage25_28_status_in));
	// A single-stage pattern left from a mode change that is no bridge code
	// reads as no fault until the next clock edge resyncs it
	assign bridge_one_rd = (bridge_mode_out && !legal_bridge(bridge_one_q)) ?
		`ECDR_BR_OK : bridge_one_q;
	assign bridge_two_rd = (bridge_mode_out && !legal_bridge(bridge_two_q)) ?
		`ECDR_BR_OK : bridge_two_q;

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			diag_one_q <= `ECDR_RST_DIAG;
			diag_two_q <= `ECDR_RST_DIAG;
			diag_three_q <= `ECDR_RST_DIAG;
			diag_four_q <= `ECDR_RST_DIAG;
			diag_five_q <= `ECDR_RST_DIAG;
			bridge_one_q <= `ECDR_RST_DIAG;
			bridge_two_q <= `ECDR_RST_DIAG;
		end else begin
			diag_one_q <= rd_one ? stage1_4_status_in :
				merge8(diag_one_q, stage1_4_status_in);
			diag_two_q <= rd_two ? stage5_8_status_in :
				merge8(diag_two_q, stage5_8_status_in);
			// Pin state bit follows the pin, never latched
			diag_three_q <= rd_three ?
				{stage13_14_status_in, watchdog_pin_state_in, 1'b0, stage9_status_in} :
				{diag_three_m[7:4], watchdog_pin_state_in, 1'b0, diag_three_m[1:0]};
			diag_four_q <= rd_four ? stage15_18_status_in :
				merge8(diag_four_q, stage15_18_status_in);
			diag_five_q <= rd_five ?
				{`ECDR_DIAG5_TOP, stage19_20_status_in} :
				{`ECDR_DIAG5_TOP, diag_five_m[3:0]};
			bridge_one_q <= bridge_one_d;
			bridge_two_q <= bridge_two_d;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @* begin
		case (addr_in)
			`ECDR_OFS_SENSOR_CFG: rdata_d = sensor_cfg_q;
			`ECDR_OFS_POWER_CFG: rdata_d = power_cfg_q;
			`ECDR_OFS_DRIVER_CFG: rdata_d = driver_cfg_q;
			`ECDR_OFS_DIAG_ONE: rdata_d = diag_one_q;
			`ECDR_OFS_DIAG_TWO: rdata_d = diag_two_q;
			`ECDR_OFS_DIAG_THREE: rdata_d = diag_three_q;
			`ECDR_OFS_DIAG_FOUR: rdata_d = diag_four_q;
			`ECDR_OFS_DIAG_FIVE: rdata_d = diag_five_q;
			`ECDR_OFS_BRIDGE_ONE: rdata_d = bridge_one_rd;
			`ECDR_OFS_BRIDGE_TWO: rdata_d = bridge_two_rd;
			default: rdata_d = 8'h00;
		endcase
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= 8'h00;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= rd_en_in;
			if (rd_en_in) begin
				rdata_out <= rdata_d;
			end
		end
	end

	// ----------------------------------------
	// Sensor interface controls
	// ----------------------------------------
	// Limited mode relies on the host never dropping filter time
	assign link_activity_monitor_enable_out = sensor_cfg_q[`ECDR_SNS_ACT_MON];
	assign sensor_adapt_filter_out = sensor_cfg_q[`ECDR_SNS_MODE_FILT];
	assign sensor_adapt_hyst_out = sensor_cfg_q[`ECDR_SNS_MODE_HYST];
	assign full_adapt = sensor_cfg_q[`ECDR_SNS_MODE_FILT:`ECDR_SNS_MODE_HYST] == `ECDR_MODE_FULL;
	assign sensor_diag_enable_out = full_adapt & sensor_cfg_q[`ECDR_SNS_DIAG_MINH];
	assign sensor_hyst_current_ua_out =
		(!full_adapt && sensor_cfg_q[`ECDR_SNS_DIAG_MINH]) ? hyst_ua(`ECDR_HYST_MIN) :
		hyst_ua(sensor_cfg_q[2:0]);

	// ----------------------------------------
	// Power policy controls
	// ----------------------------------------
	assign transceiver_error_enable_out = power_cfg_q[`ECDR_PWR_XCVR_ERR];
	assign key_on_reset_enable_out = power_cfg_q[`ECDR_PWR_KEY_RST];
	assign latch_secure_off_enabled_out = ~power_cfg_q[`ECDR_PWR_LATCH_N];
	assign main_relay_driver_off_out = ~key_on_in & ~latch_secure_off_enabled_out;
	assign supplies_off_out = main_relay_driver_off_out &
		~power_cfg_q[`ECDR_PWR_KEEP_ON];
	assign uv_outputs_off_out = supply_uv_in & ~power_cfg_q[`ECDR_PWR_UV_MASK];
	assign watchdog_response_time_out = power_cfg_q[`ECDR_PWR_WD_BASE];
	assign secure_off_priority_out = power_cfg_q[`ECDR_PWR_PRIO];
	assign off_at_key_out = power_cfg_q[`ECDR_PWR_LATCH_N] &
		~power_cfg_q[`ECDR_PWR_PRIO];
	assign off_on_watchdog_out = power_cfg_q[`ECDR_PWR_PRIO];
	assign off_at_timer_out = ~power_cfg_q[`ECDR_PWR_LATCH_N] &
		~power_cfg_q[`ECDR_PWR_PRIO];
	assign secure_off_enable_out = ~power_cfg_q[`ECDR_PWR_LATCH_N];

	// Forced low only while the output is enabled and undervoltage stands
	assign uv_force_low = power_cfg_q[`ECDR_PWR_UV_SDO] & supply_uv_in & sdo_enable_in;

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			serial_data_out <= 1'b0;
		end else begin
			serial_data_out <= uv_force_low ? 1'b0 : sdo_data_in;
		end
	end

	// ----------------------------------------
	// Driver diagnosis and stage mode
	// ----------------------------------------
	assign ignition_battery_diag_latch_out = driver_cfg_q[`ECDR_DRV_BAT_LATCH];
	assign ignition_ground_diag_select_out = driver_cfg_q[`ECDR_DRV_GND_SEL];
	assign diag_mask_double_out = driver_cfg_q[`ECDR_DRV_MASK_X2];
	assign low_battery_enable_out = driver_cfg_q[`ECDR_DRV_LB25:`ECDR_DRV_LB13];
	// Low battery on 21 or 25 overrides the bridge selection
	assign stages_independent_out = ~stage_cfg_q[`ECDR_STG_BRIDGE] |
		driver_cfg_q[`ECDR_DRV_LB25] | driver_cfg_q[`ECDR_DRV_LB21];
	assign bridge_mode_out = ~stages_independent_out;

endmodule // ecdr_regs

`default_nettype wire

// [test/ecdr_monitor.sv]
// Assertion checker watching the register bank ports.
// Assumes the bind below attaches it to every bank instance.
`timescale 1ns/1ps
`default_nettype none
module ecdr_monitor (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [7:0] rdata_out,
	input wire logic rvalid_out,
	input wire logic key_on_in,
	input wire logic link_activity_monitor_enable_out,
	input wire logic sensor_diag_enable_out,
	input wire logic sensor_adapt_filter_out,
	input wire logic sensor_adapt_hyst_out,
	input wire logic latch_secure_off_enabled_out,
	input wire logic main_relay_driver_off_out,
	input wire logic supplies_off_out,
	input wire logic uv_outputs_off_out,
	input wire logic [3:0] low_battery_enable_out,
	input wire logic bridge_mode_out,
	input wire logic stages_independent_out
);
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	AST_READ_ANSWER:
		assert property (rd_en_in |=> rvalid_out) else $error("read not answered");
	AST_DIAG5_TOP:
		assert property (rd_en_in && addr_in == 4'h2 |=> rdata_out[7:4] == 4'hf)
			else $error("unused diag bits not ones");
	AST_MON_WRITE:
		assert property (wr_en_in && addr_in == 4'h0 |=>
			link_activity_monitor_enable_out == $past(wdata_in[6])) else $error("monitor enable");
	AST_LATCH_WRITE:
		assert property (wr_en_in && addr_in == 4'h4 |=>
			latch_secure_off_enabled_out != $past(wdata_in[5])) else $error("latch enable");
	AST_UV_MASKED:
		assert property (wr_en_in && addr_in == 4'h4 && wdata_in[3] |=> !uv_outputs_off_out)
			else $error("masked undervoltage switched off");
	AST_RELAY_OFF:
		assert property (main_relay_driver_off_out == (!key_on_in && !latch_secure_off_enabled_out))
			else $error("relay driver state");
	AST_SUPPLY_OFF:
		assert property (supplies_off_out |-> main_relay_driver_off_out) else $error("supplies off");
	AST_FULL_DIAG:
		assert property (sensor_diag_enable_out |-> sensor_adapt_filter_out && sensor_adapt_hyst_out)
			else $error("sensor diag outside full mode");
	AST_INDEP:
		assert property (|low_battery_enable_out[3:2] |-> stages_independent_out && !bridge_mode_out)
			else $error("low battery left bridges");
	AST_BRIDGE_CODE:
		assert property (rd_en_in && addr_in == 4'h6 && bridge_mode_out |=>
			rdata_out inside {8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07, 8'hff})
			else $error("undefined bridge code");
endmodule // ecdr_monitor
bind ecdr_regs ecdr_monitor ecdr_monitor_i (.clk_in, .resetn_in, .wr_en_in, .rd_en_in,
	.addr_in, .wdata_in, .rdata_out, .rvalid_out, .key_on_in, .link_activity_monitor_enable_out,
	.sensor_diag_enable_out, .sensor_adapt_filter_out, .sensor_adapt_hyst_out,
	.latch_secure_off_enabled_out, .main_relay_driver_off_out, .supplies_off_out,
	.uv_outputs_off_out, .low_battery_enable_out, .bridge_mode_out, .stages_independent_out);
`default_nettype wire

// [test/ecdr_host.sv]
// Host model issuing write and read strobes to the register bank.
// Assumes one request at a time, launched 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ecdr_host (
	input wire logic clk_in,
	input wire logic rvalid_in,
	input wire logic [7:0] rdata_in,
	output logic wr_en_out,
	output logic stage_cfg_wr_out,
	output logic rd_en_out,
	output logic [3:0] addr_out,
	output logic [7:0] wdata_out
);
	bit filt_on = 1'b0;
	initial begin
		{wr_en_out, stage_cfg_wr_out, rd_en_out, addr_out, wdata_out} = '0;
	end
	// Kind 0 writes, 1 writes stage config, 2 reads; x when no answer
	task automatic xfer(input int k, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_in);
		#1;
		if (k == 0 && a == 4'h0 && filt_on) d[4] = 1'b1;
		if (k == 0 && a == 4'h0 && d[4]) filt_on = 1'b1;
		addr_out = a;
		wdata_out = d;
		wr_en_out = (k == 0);
		stage_cfg_wr_out = (k == 1);
		rd_en_out = (k == 2);
		@(posedge clk_in);
		#1;
		q = rvalid_in ? rdata_in : 8'hxx;
		{wr_en_out, stage_cfg_wr_out, rd_en_out} = 3'b000;
		// Idle lines show the inverse, never a stale value
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule // ecdr_host
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the configuration and diagnosis register bank.
// Assumes ecdr_host as bus partner and ecdr_monitor bound onto the bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic wr_en_in, stage_cfg_wr_in, rd_en_in, rvalid_out, watchdog_pin_state_in;
	logic key_on_in, supply_uv_in, sdo_data_in, sdo_enable_in, serial_data_out;
	logic [1:0] stage9_status_in;
	logic [3:0] addr_in, stage13_14_status_in, stage19_20_status_in, low_battery_enable_out;
	logic [5:0] sensor_hyst_current_ua_out;
	logic [7:0] wdata_in, rdata_out, stage1_4_status_in, stage5_8_status_in, q, v, e;
	logic [7:0] stage15_18_status_in, stage21_24_status_in, stage25_28_status_in;
	logic [7:0] bridge1_code_in, bridge2_code_in, m_s, m_p, m_d;
	logic link_activity_monitor_enable_out, sensor_diag_enable_out, sensor_adapt_filter_out;
	logic sensor_adapt_hyst_out, transceiver_error_enable_out, key_on_reset_enable_out;
	logic latch_secure_off_enabled_out, supplies_off_out, main_relay_driver_off_out;
	logic uv_outputs_off_out, watchdog_response_time_out, secure_off_priority_out;
	logic off_at_key_out, off_on_watchdog_out, off_at_timer_out, secure_off_enable_out;
	logic ignition_battery_diag_latch_out, ignition_ground_diag_select_out;
	logic diag_mask_double_out, bridge_mode_out, stages_independent_out, m_g;
	int errors = 0;
	int checks_done = 0;
	int seed = 64142;
	int cur[8] = '{17, 5, 10, 17, 32, 51, 17, 0};
	logic [7:0] codes[7] = '{8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07, 8'hff};
	logic [3:0] offs[7] = '{4'h1, 4'h5, 4'h9, 4'hd, 4'h2, 4'h6, 4'ha};

	always #25 clk_in = ~clk_in;
	ecdr_regs ecdr_regs_i (.*);
	ecdr_host ecdr_host_i (.clk_in(clk_in), .rvalid_in(rvalid_out), .rdata_in(rdata_out),
		.wr_en_out(wr_en_in), .stage_cfg_wr_out(stage_cfg_wr_in), .rd_en_out(rd_en_in),
		.addr_out(addr_in), .wdata_out(wdata_in));
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		checks_done++;
		if (g !== x) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		ecdr_host_i.xfer(2, a, 8'h00, d);
	endtask
	task automatic wr(input int k, input logic [3:0] a, input logic [7:0] d);
		logic [7:0] z;
		ecdr_host_i.xfer(k, a, d, z);
	endtask
	task automatic live(input logic [3:0] a, input logic [7:0] d);
		case (a)
			4'h1: stage1_4_status_in = d;
			4'h5: stage5_8_status_in = d;
			4'h9: {stage13_14_status_in, watchdog_pin_state_in, stage9_status_in} = {d[7:3], d[1:0]};
			4'hd: stage15_18_status_in = d;
			4'h2: stage19_20_status_in = d[3:0];
			4'h6: {bridge1_code_in, stage21_24_status_in} = {d, d};
			default: {bridge2_code_in, stage25_28_status_in} = {d, d};
		endcase
	endtask
	// Fault pulse, back to no fault, then read twice
	task automatic diag_round(input logic [3:0] a, input logic [7:0] v, input logic [7:0] x);
		logic [7:0] z;
		logic [7:0] d;
		z = (a == 4'h9) ? {4'hf, v[3], 3'b011} : 8'hff;
		live(a, v);
		repeat (2) @(posedge clk_in);
		#1;
		live(a, z | 8'h04);
		rd(a, d);
		chk("diag held", x, d);
		rd(a, d);
		chk("diag cleared", z, d);
	endtask
	task automatic chk_cfg();
		logic [7:0] x;
		logic [7:0] g;
		x = {2'b00, (m_s[4:3] != 2'b11 && m_s[5]) ? 6'd5 : 6'(cur[m_s[2:0]])};
		chk("current", x, {2'b00, sensor_hyst_current_ua_out});
		x = {4'h0, m_s[6], m_s[4:3], m_s[4:3] == 2'b11 && m_s[5]};
		g = {4'h0, link_activity_monitor_enable_out, sensor_adapt_filter_out,
			sensor_adapt_hyst_out, sensor_diag_enable_out};
		chk("sensor", x, g);
		x = {m_p[7:6], ~m_p[5], ~key_on_in & m_p[5], ~key_on_in & m_p[5] & ~m_p[4],
			supply_uv_in & ~m_p[3], m_p[1:0]};
		g = {transceiver_error_enable_out, key_on_reset_enable_out, latch_secure_off_enabled_out,
			main_relay_driver_off_out, supplies_off_out, uv_outputs_off_out,
			watchdog_response_time_out, secure_off_priority_out};
		chk("power", x, g);
		x = {m_p[5] & ~m_p[0], m_p[0], ~m_p[5] & ~m_p[0], ~m_p[5], m_d[7:5], ~m_g | |m_d[3:2]};
		g = {off_at_key_out, off_on_watchdog_out, off_at_timer_out, secure_off_enable_out,
			ignition_battery_diag_latch_out, ignition_ground_diag_select_out,
			diag_mask_double_out, stages_independent_out};
		chk("off source", x, g);
		x = {3'h0, m_g & ~|m_d[3:2], m_d[3:0]};
		chk("stages", x, {3'h0, bridge_mode_out, low_battery_enable_out});
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------
	// Sequence
	// ----------------
	initial begin
		{key_on_in, supply_uv_in, sdo_data_in, sdo_enable_in} = 4'h8;
		for (int i = 0; i < 7; i++) live(offs[i], 8'hff);
		{m_s, m_p, m_d, m_g} = {8'hd8, 8'h22, 8'h50, 1'b1};
		repeat (10) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		rd(4'h0, q);
		chk("sensor reset", m_s, q);
		rd(4'h4, q);
		chk("power reset", m_p, q);
		rd(4'h8, q);
		chk("driver reset", m_d, q);
		chk_cfg();
		rd(4'hf, q);
		chk("unmapped", 8'h00, q);
		wr(0, 4'h1, 8'h00);
		rd(4'h1, q);
		chk("diag write ignored", 8'hff, q);
		$display("test reset done");
		for (int i = 0; i < 64; i++) begin
			m_s = {2'b01, i[0], i[5:1]};
			wr(0, 4'h0, m_s);
			chk_cfg();
		end
		$display("test sensor modes done");
		for (int m = 1; m >= 0; m--) begin
			m_g = m[0];
			wr(1, 4'h0, {7'h00, m_g});
			rd(4'h6, q);
			rd(4'ha, q);
			for (int r = 0; r < 8; r++) begin
				for (int i = 0; i < 7; i++) begin
					v = 8'($random(seed));
					if (i > 4 && m_g) v = (r == 7) ? 8'h08 : codes[r];
					e = (i == 2) ? {v[7:3], 1'b0, v[1:0]} : (i == 4) ? {4'hf, v[3:0]} : v;
					if (i > 4 && m_g && r == 7) e = 8'hff;
					diag_round(offs[i], v, e);
				end
			end
		end
		$display("test diagnosis done");
		for (int i = 0; i < 200; i++) begin
			{m_p, m_d, m_g} = 17'($random(seed));
			m_s = 8'($random(seed)) | 8'h10;
			wr(0, 4'h0, m_s);
			wr(0, 4'h4, m_p);
			wr(0, 4'h8, m_d);
			wr(1, 4'h0, {7'h00, m_g});
			{key_on_in, supply_uv_in, sdo_data_in, sdo_enable_in} = 4'($random(seed));
			rd(4'h4, q);
			chk("power readback", m_p, q);
			e = {7'h00, ~(m_p[2] & supply_uv_in & sdo_enable_in) & sdo_data_in};
			chk("serial out", e, {7'h00, serial_data_out});
			chk_cfg();
		end
		$display("test random config done");
		complete_run();
	end
	// Run needs about 2800 cycles; eight times that cuts a hang
	initial begin
		#1_200_000;
		errors++;
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
